// ### src/aux_text_subcode_serial_out.sv
// Side-channel serial port: subcode stream or text stream, one at a time.
// Assumes an APB master on pclk, pins arriving asynchronously, and an upstream
// text word source on pclk using a valid/ready pulse handshake.
`timescale 1ns/1ns
`default_nettype none
module aux_text_subcode_serial_out
  import aux_serial_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SUB_BITS-1:0] sub_symbol_in,
  input wire logic [UNIT_BITS-1:0] text_word_in,
  input wire logic text_word_valid,
  output logic text_word_ready,
  output logic block_sync_out,
  output logic frame_sync_out,
  output logic side_serial_out,
  input wire logic side_read_clock_in,
  input wire logic [GROUPS-1:0] text_request_in,
  input wire logic [GROUPS-1:0] text_clock_in,
  output logic [GROUPS-1:0] text_clock_out,
  output logic [GROUPS-1:0] text_clock_oe,
  output logic [GROUPS-1:0] text_serial_out,
  output logic [GROUPS-1:0] text_serial_oe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [GROUPS-1:0] req_meta, req_sync, tck_meta, tck_sync, tck_prev;
  logic side_read_clock_in_meta, side_read_clock_in_sync, side_read_clock_in_prev;

  // Two flops on every pin; edge detection only looks at the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= '0;
      req_sync <= '0;
      tck_meta <= '0;
      tck_sync <= '0;
      tck_prev <= '0;
      side_read_clock_in_meta <= 1'b0;
      side_read_clock_in_sync <= 1'b0;
      side_read_clock_in_prev <= 1'b0;
    end else begin
      req_meta <= text_request_in;
      req_sync <= req_meta;
      tck_meta <= text_clock_in;
      tck_sync <= tck_meta;
      tck_prev <= tck_sync;
      side_read_clock_in_meta <= side_read_clock_in;
      side_read_clock_in_sync <= side_read_clock_in_meta;
      side_read_clock_in_prev <= side_read_clock_in_sync;
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl, next_ctrl;
  logic [2:0] div_half, next_div;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] units, next_units;
  text_state_t state, next_state;
  logic [6:0] fidx, next_fidx;

  // Register index from address; 3 means unmapped
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == CTRL_OFF) begin
      return 2'h0;
    end else if (a == DIV_OFF) begin
      return 2'h1;
    end else if (a == STAT_OFF) begin
      return 2'h2;
    end else begin
      return 2'h3;
    end
  endfunction

  wire logic enable = ctrl[CTRL_EN];
  wire logic text_on = enable & ctrl[CTRL_TEXT];
  wire logic sub_on = enable & ~ctrl[CTRL_TEXT];
  wire logic dev_clk = ctrl[CTRL_DEVCLK];
  wire logic idle_hi = ctrl[CTRL_IDLEHI];
  wire logic [1:0] grp = ctrl[CTRL_GRP_LSB +: 2];
  wire logic [1:0] speed = ctrl[CTRL_SPD_LSB +: 2];

  // Read data is prepared in setup, so every access ends in its first cycle
  always_comb begin
    next_ctrl = ctrl;
    next_div = div_half;
    next_pready = psel & ~penable;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      if (reg_sel(paddr) == 2'h0) begin
        next_prdata = {24'h00_0000, ctrl};
      end else if (reg_sel(paddr) == 2'h1) begin
        next_prdata = {29'h0000_0000, div_half};
      end else if (reg_sel(paddr) == 2'h2) begin
        next_prdata = {units, 1'b0, fidx, 5'h00, frame_sync_out, block_sync_out,
                       state != ST_IDLE};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (reg_sel(paddr) == 2'h0) begin
        next_ctrl = pwdata[7:0];
        // Only three pin groups and three speeds exist
        if (pwdata[CTRL_GRP_LSB +: 2] == 2'h3) next_ctrl[CTRL_GRP_LSB +: 2] = 2'h0;
        if (pwdata[CTRL_SPD_LSB +: 2] == 2'h3) next_ctrl[CTRL_SPD_LSB +: 2] = 2'h2;
      end else if (reg_sel(paddr) == 2'h1) begin
        // Clamp keeps the generated clock inside its legal band
        if (pwdata[31:0] < DIV_MIN) begin
          next_div = 3'(DIV_MIN);
        end else if (pwdata[31:0] > DIV_MAX) begin
          next_div = 3'(DIV_MAX);
        end else begin
          next_div = pwdata[2:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      div_half <= DIV_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      div_half <= next_div;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Subcode stream
  // ----------------------------------------------------------------
  logic [10:0] fcnt, next_fcnt;
  logic [SUB_BITS-1:0] sshr, next_sshr;
  logic next_fsync, next_bsync, next_sout;
  wire logic [10:0] frame_len = 11'(FRAME_CYCLES) >> speed;
  wire logic side_read_clock_in_rise = side_read_clock_in_sync & ~side_read_clock_in_prev;

  // Frame timer drives both syncs; a symbol is captured at each frame start
  always_comb begin
    // Parked on the last cycle of the last frame, so enabling opens a whole frame
    next_fcnt = frame_len - 11'h001;
    next_fidx = 7'(BLOCK_FRAMES - 1);
    next_sshr = sshr;
    next_sout = side_serial_out;
    if (sub_on) begin
      // At or past the end also covers a speed step that shortens the frame
      if (fcnt >= frame_len - 11'h001) begin
        next_fcnt = 11'h000;
        next_fidx = (fidx == 7'(BLOCK_FRAMES - 1)) ? 7'h00 : fidx + 7'h01;
        next_sshr = sub_symbol_in;
      end else begin
        next_fcnt = fcnt + 11'h001;
        next_fidx = fidx;
        if (side_read_clock_in_rise) begin
          next_sout = sshr[SUB_BITS-1];
          next_sshr = {sshr[SUB_BITS-2:0], 1'b0};
        end
      end
    end else begin
      next_sout = 1'b0;
    end
    next_fsync = sub_on & (next_fcnt < 11'(FSYNC_CYCLES));
    next_bsync = sub_on & (next_fidx < 7'(SYNC_FRAMES));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt <= 11'h000;
      fidx <= 7'h00;
      sshr <= '0;
      side_serial_out <= 1'b0;
      frame_sync_out <= 1'b0;
      block_sync_out <= 1'b0;
    end else begin
      fcnt <= next_fcnt;
      fidx <= next_fidx;
      sshr <= next_sshr;
      side_serial_out <= next_sout;
      frame_sync_out <= next_fsync;
      block_sync_out <= next_bsync;
    end
  end

  // ----------------------------------------------------------------
  // Text stream engine
  // ----------------------------------------------------------------
  logic [UNIT_BITS-1:0] shreg, next_shreg;
  logic [4:0] bitcnt, next_bitcnt;
  logic [2:0] dcnt, next_dcnt;
  logic tclk, next_tclk, tdata, next_tdata, next_ready;
  logic [GROUPS-1:0] next_ck_out, next_ck_oe, next_d_out, next_d_oe;
  wire logic req = req_sync[grp];
  wire logic hin = tck_sync[grp];
  wire logic hprev = tck_prev[grp];
  // Data changes on the edge away from the idle level
  wire logic host_change = idle_hi ? (hprev & ~hin) : (~hprev & hin);
  wire logic unit_edge = (bitcnt == 5'h00) || (bitcnt == 5'(UNIT_BITS));

  // Load, shift or close one unit; loading pulses the word source ready
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_dcnt = dcnt;
    next_tclk = tclk;
    next_tdata = tdata;
    next_ready = 1'b0;
    next_units = units;
    case (state)
      ST_IDLE: begin
        next_tclk = 1'b0;
        next_tdata = 1'b0;
        next_bitcnt = 5'h00;
        if (text_on && req) begin
          if (!dev_clk) begin
            next_state = ST_HOST;
          end else if (text_word_valid) begin
            next_state = ST_DEV_HI;
            next_tclk = 1'b1;
            next_tdata = text_word_in[UNIT_BITS-1];
            next_shreg = {text_word_in[UNIT_BITS-2:0], 1'b0};
            next_bitcnt = 5'h01;
            next_dcnt = 3'h0;
            next_ready = 1'b1;
            next_units = units + 16'h0001;
          end
        end
      end
      ST_HOST: begin
        if (unit_edge && !req) begin
          next_state = ST_IDLE;
          next_tdata = 1'b0;
        end else if (host_change) begin
          if (unit_edge) begin
            if (text_word_valid) begin
              next_tdata = text_word_in[UNIT_BITS-1];
              next_shreg = {text_word_in[UNIT_BITS-2:0], 1'b0};
              next_bitcnt = 5'h01;
              next_ready = 1'b1;
              next_units = units + 16'h0001;
            end else begin
              next_tdata = 1'b0;
              next_bitcnt = 5'h00;
            end
          end else begin
            next_tdata = shreg[UNIT_BITS-1];
            next_shreg = {shreg[UNIT_BITS-2:0], 1'b0};
            next_bitcnt = bitcnt + 5'h01;
          end
        end
      end
      ST_DEV_HI: begin
        next_dcnt = dcnt + 3'h1;
        if (dcnt == div_half - 3'h1) begin
          next_dcnt = 3'h0;
          next_tclk = 1'b0;
          next_state = ST_DEV_LO;
          if (bitcnt == 5'(UNIT_BITS)) begin
            if (req && text_word_valid) begin
              next_tdata = text_word_in[UNIT_BITS-1];
              next_shreg = {text_word_in[UNIT_BITS-2:0], 1'b0};
              next_bitcnt = 5'h01;
              next_ready = 1'b1;
              next_units = units + 16'h0001;
            end else begin
              next_state = ST_IDLE;
              next_tdata = 1'b0;
            end
          end else begin
            next_tdata = shreg[UNIT_BITS-1];
            next_shreg = {shreg[UNIT_BITS-2:0], 1'b0};
            next_bitcnt = bitcnt + 5'h01;
          end
        end
      end
      ST_DEV_LO: begin
        next_dcnt = dcnt + 3'h1;
        if (dcnt == div_half - 3'h1) begin
          next_dcnt = 3'h0;
          next_tclk = 1'b1;
          next_state = ST_DEV_HI;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Leaving text mode aborts at once; the host sees the pins released
    if (!text_on) begin
      next_state = ST_IDLE;
      next_tclk = 1'b0;
      next_tdata = 1'b0;
      next_bitcnt = 5'h00;
    end
    next_ck_out = '0;
    next_ck_oe = '0;
    next_d_out = '0;
    next_d_oe = '0;
    next_ck_out[grp] = next_tclk;
    next_ck_oe[grp] = text_on & dev_clk;
    next_d_out[grp] = next_tdata;
    next_d_oe[grp] = text_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      shreg <= '0;
      bitcnt <= 5'h00;
      dcnt <= 3'h0;
      tclk <= 1'b0;
      tdata <= 1'b0;
      units <= 16'h0000;
      text_word_ready <= 1'b0;
      text_clock_out <= '0;
      text_clock_oe <= '0;
      text_serial_out <= '0;
      text_serial_oe <= '0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      dcnt <= next_dcnt;
      tclk <= next_tclk;
      tdata <= next_tdata;
      units <= next_units;
      text_word_ready <= next_ready;
      text_clock_out <= next_ck_out;
      text_clock_oe <= next_ck_oe;
      text_serial_out <= next_d_out;
      text_serial_oe <= next_d_oe;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and their helper counters
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic fs_prev;
  logic [10:0] fs_gap;
  logic fs_armed;
  logic [1:0] bs_frames;
  logic [2:0] hi_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev <= 1'b0;
      fs_gap <= 11'h000;
      fs_armed <= 1'b0;
      bs_frames <= 2'h0;
      hi_len <= 3'h0;
    end else begin
      fs_prev <= frame_sync_out;
      if (!sub_on || next_ctrl != ctrl) begin
        fs_gap <= 11'h000;
        fs_armed <= 1'b0;
      end else if (frame_sync_out && !fs_prev) begin
        fs_gap <= 11'h001;
        fs_armed <= 1'b1;
      end else begin
        fs_gap <= fs_gap + 11'h001;
      end
      if (block_sync_out && !fs_prev && frame_sync_out) bs_frames <= bs_frames + 2'h1;
      else if (!block_sync_out) bs_frames <= 2'h0;
      hi_len <= (state == ST_DEV_HI) ? hi_len + 3'h1 : 3'h0;
    end
  end

  sequence frame_rise_s;
    $rose(frame_sync_out);
  endsequence
  sequence frame_pulse_s;
    frame_sync_out [*8] ##1 !frame_sync_out;
  endsequence

  fsync_width_a: assert property (frame_rise_s |-> frame_pulse_s)
    else $error("frame sync pulse width wrong");
  fsync_period_a: assert property ((frame_rise_s and (fs_armed && sub_on))
    |-> fs_gap == frame_len)
    else $error("frame sync period wrong");
  bsync_frames_a: assert property ($fell(block_sync_out) |-> $past(bs_frames) == 2'h2)
    else $error("block sync not two frames long");
  bsync_align_a: assert property ($rose(block_sync_out) |-> $rose(frame_sync_out) && fidx == 7'h00)
    else $error("block sync not aligned to frame start");
  only_one_a: assert property (text_serial_oe != '0 |-> !frame_sync_out && !block_sync_out)
    else $error("text and subcode both active");
  sub_shift_a: assert property (sub_on && side_read_clock_in_rise && fcnt < frame_len - 11'h001 && $stable(ctrl)
    |=> side_serial_out == $past(sshr[SUB_BITS-1]))
    else $error("subcode bit not presented on read clock");
  unit_start_a: assert property (text_word_ready |-> bitcnt == 5'h01 &&
    ($past(bitcnt) == 5'h00 || $past(bitcnt) == 5'(UNIT_BITS)))
    else $error("word taken mid unit");
  dev_start_a: assert property (state == ST_IDLE ##1 state == ST_DEV_HI |-> tclk && bitcnt == 5'h01)
    else $error("device clock did not start high");
  dev_half_a: assert property (state == ST_DEV_HI ##1 state != ST_DEV_HI && text_on
    |-> $past(hi_len) == div_half - 3'h1)
    else $error("device clock high phase wrong");
  div_band_a: assert property (div_half >= 3'(DIV_MIN) && div_half <= 3'(DIV_MAX))
    else $error("divider outside legal band");
  unit_finish_a: assert property (text_on && state != ST_IDLE && !unit_edge && $stable(ctrl)
    |=> state != ST_IDLE)
    else $error("unit abandoned before sixteen bits");
  host_shift_a: assert property (state == ST_HOST && host_change && !unit_edge && text_on
    |=> tdata == $past(shreg[UNIT_BITS-1]))
    else $error("host mode data not shifted on change edge");

endmodule
`default_nettype wire

// ### src/aux_serial_pkg.sv
// Constants, register map and state type for the side-channel serial port.
// Assumes a single 10 MHz APB clock; the frame length and divider limits below are derived from it.
package aux_serial_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_KHZ = 10000;
  localparam int unsigned FRAME_US = 136;
  localparam int unsigned FRAME_CYCLES = FRAME_US * PCLK_KHZ / 1000;
  localparam int unsigned BLOCK_FRAMES = 98;
  localparam int unsigned SYNC_FRAMES = 2;
  localparam int unsigned FSYNC_CYCLES = 8;
  localparam int unsigned TCLK_MAX_KHZ = 4200;
  localparam int unsigned TCLK_MIN_KHZ = 1050;
  localparam int unsigned DIV_MIN = (PCLK_KHZ + 2 * TCLK_MAX_KHZ - 1) / (2 * TCLK_MAX_KHZ);
  localparam int unsigned DIV_MAX = PCLK_KHZ / (2 * TCLK_MIN_KHZ);
  localparam int unsigned UNIT_BITS = 16;
  localparam int unsigned SUB_BITS = 8;
  localparam int unsigned GROUPS = 3;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DIV_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_TEXT = 1;
  localparam int unsigned CTRL_DEVCLK = 2;
  localparam int unsigned CTRL_IDLEHI = 3;
  localparam int unsigned CTRL_GRP_LSB = 4;
  localparam int unsigned CTRL_SPD_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] DIV_RESET = 3'h4;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_BSYNC = 1;
  localparam int unsigned STAT_FSYNC = 2;
  localparam int unsigned STAT_FIDX_LSB = 8;
  localparam int unsigned STAT_UNITS_LSB = 16;

  // ----------------------------------------------------------------
  // Text engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOST = 2'b01,
    ST_DEV_HI = 2'b10,
    ST_DEV_LO = 2'b11
  } text_state_t;

endpackage

// ### tb/host_model.sv
// Host controller model: reads the subcode stream and the text stream.
// Assumes pclk at 10 MHz; all pins change just after a pclk rising edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire logic side_serial_out,
  input wire logic [2:0] text_clock_out,
  input wire logic [2:0] text_serial_out,
  output logic side_read_clock_in,
  output logic [2:0] text_request_in,
  output logic [2:0] text_clock_in
);
  // Clocks stand still between transfers
  initial begin
    side_read_clock_in = 1'b0;
    text_request_in = 3'h0;
    text_clock_in = 3'h0;
  end

  // ----------------------------------------------------------------
  // Subcode read
  // ----------------------------------------------------------------
  // Bit sampled 4 pclk after each rise, so the 3-cycle sync delay has passed
  task automatic sub_read(output logic [7:0] v);
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      side_read_clock_in <= 1'b1;
      repeat (4) @(posedge pclk);
      v[7-i] = side_serial_out;
      side_read_clock_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Text handshake
  // ----------------------------------------------------------------
  // Idle level is set before the mode is chosen, so no stray edge counts
  task automatic idle(input logic hi);
    @(posedge pclk);
    text_clock_in <= {3{hi}};
  endtask

  // Raise or drop a request; 1000 ns pass before any clock edge
  task automatic request(input int g, input logic lvl);
    @(posedge pclk);
    text_request_in[g] <= lvl;
    repeat (10) @(posedge pclk);
  endtask

  // 800 ns period: leave idle is the change edge, return is capture
  task automatic host_unit(input int g, input logic hi, output logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      text_clock_in[g] <= ~hi;
      repeat (4) @(posedge pclk);
      v[15-i] = text_serial_out[g];
      text_clock_in[g] <= hi;
      repeat (3) @(posedge pclk);
    end
  endtask

  // Capture on each rise of the device clock; request drops after drop_at bits
  task automatic dev_unit(input int g, input int drop_at, output logic [15:0] v,
                          output int start_n, output int per);
    int n;
    int bits;
    int last;
    logic prev;
    n = 0;
    bits = 0;
    last = 0;
    @(posedge pclk);
    text_request_in[g] <= 1'b1;
    prev = text_clock_out[g];
    while (bits < 16 && n < 2000) begin
      @(posedge pclk);
      n++;
      if (text_clock_out[g] === 1'b1 && prev === 1'b0) begin
        if (bits == 0) start_n = n;
        if (bits == 1) per = n - last;
        last = n;
        v[15-bits] = text_serial_out[g];
        bits++;
        if (bits == drop_at) text_request_in[g] <= 1'b0;
      end
      prev = text_clock_out[g];
    end
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: APB register access, subcode timing and the text streams.
// Assumes the design package and the host model; run stays under 95000 pclk.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aux_serial_pkg::*;
  localparam logic [63:0] WORDS = 64'h1234_C3A6_5A0F_FFFE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic e, side_read_clock_in, side_serial_out, block_sync_out, frame_sync_out;
  logic text_word_valid, text_word_ready;
  logic [15:0] text_word_in, v;
  logic [7:0] sv;
  logic [2:0] widx, text_request_in, text_clock_in, text_clock_out;
  logic [2:0] text_clock_oe, text_serial_out, text_serial_oe;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int a, b, s, p;

  aux_text_subcode_serial_out u_aux_text_subcode_serial_out (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_symbol_in(8'hA5), .text_word_in(text_word_in),
    .text_word_valid(text_word_valid), .text_word_ready(text_word_ready),
    .block_sync_out(block_sync_out), .frame_sync_out(frame_sync_out),
    .side_serial_out(side_serial_out), .side_read_clock_in(side_read_clock_in),
    .text_request_in(text_request_in), .text_clock_in(text_clock_in),
    .text_clock_out(text_clock_out), .text_clock_oe(text_clock_oe),
    .text_serial_out(text_serial_out), .text_serial_oe(text_serial_oe)
  );
  host_model u_host_model (
    .pclk(pclk), .side_serial_out(side_serial_out), .text_clock_out(text_clock_out),
    .text_serial_out(text_serial_out), .side_read_clock_in(side_read_clock_in),
    .text_request_in(text_request_in), .text_clock_in(text_clock_in)
  );

  // ----------------------------------------------------------------
  // Clock, word source and timeout
  // ----------------------------------------------------------------
  always #50 pclk = ~pclk;
  // Stand-in for the memory buffer: a word is used up on each ready pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) widx <= 3'h0;
    else if (text_word_ready === 1'b1 && widx < 3'h4) widx <= widx + 3'h1;
  end
  assign text_word_in = WORDS[16 * (3 - widx[1:0]) +: 16];
  assign text_word_valid = (widx < 3'h4);
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits on pready for as long as it takes, the timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Count cycles until a sync output reaches a level (w 0 frame, 1 block)
  task automatic wait_lvl(input int w, input logic val, output int n);
    n = 0;
    while (((w == 0) ? frame_sync_out : block_sync_out) !== val && n < 40000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of control and divider, and an unmapped place
    apb(1'b0, CTRL_OFF, 32'h0, d, e);
    check(d, 32'h0);
    apb(1'b0, DIV_OFF, 32'h0, d, e);
    check(d, 32'h4);
    apb(1'b0, 8'h0C, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    $display("registers done");
    // Subcode at 1x: frame period, sync width, one symbol MSB first
    apb(1'b1, CTRL_OFF, 32'h1, d, e);
    wait_lvl(0, 1'b0, a);
    wait_lvl(0, 1'b1, a);
    wait_lvl(0, 1'b0, a);
    wait_lvl(0, 1'b1, b);
    check(32'(a), 32'(FSYNC_CYCLES));
    check(32'(a + b), 32'h550);
    u_host_model.sub_read(sv);
    check({24'h0, sv}, 32'hA5);
    // Subcode at 4x: frame and block timing scale with speed
    apb(1'b1, CTRL_OFF, 32'h81, d, e);
    wait_lvl(1, 1'b0, a);
    wait_lvl(1, 1'b1, a);
    wait_lvl(1, 1'b0, a);
    wait_lvl(1, 1'b1, b);
    check(32'(a), 32'h2A8);
    check(32'(a + b), 32'h8228);
    // Leave subcode only after block and frame sync have fallen on their own
    wait_lvl(1, 1'b0, a);
    wait_lvl(0, 1'b0, a);
    $display("subcode done");
    // Host clock idling low, then high, on group 1
    u_host_model.idle(1'b0);
    apb(1'b1, CTRL_OFF, 32'h13, d, e);
    u_host_model.request(1, 1'b1);
    u_host_model.host_unit(1, 1'b0, v);
    check({16'h0, v}, 32'h1234);
    check({26'h0, text_serial_oe, frame_sync_out, block_sync_out, 1'b0}, 32'h10);
    u_host_model.request(1, 1'b0);
    u_host_model.idle(1'b1);
    apb(1'b1, CTRL_OFF, 32'h1B, d, e);
    u_host_model.request(1, 1'b1);
    u_host_model.host_unit(1, 1'b1, v);
    check({16'h0, v}, 32'hC3A6);
    u_host_model.request(1, 1'b0);
    $display("host clocked done");
    // Device clock at 2.5 MHz; request drops after the fourth bit
    apb(1'b1, DIV_OFF, 32'h2, d, e);
    apb(1'b0, DIV_OFF, 32'h0, d, e);
    check(d, 32'h2);
    apb(1'b1, CTRL_OFF, 32'h17, d, e);
    u_host_model.dev_unit(1, 4, v, s, p);
    check({16'h0, v}, 32'h5A0F);
    check(32'(s <= 128), 32'h1);
    check(32'(p), 32'h4);
    repeat (128) @(posedge pclk);
    check({29'h0, text_clock_out[1], text_serial_out[1], 1'b0}, 32'h0);
    check({29'h0, text_clock_oe}, 32'h2);
    apb(1'b0, STAT_OFF, 32'h0, d, e);
    check({16'h0, d[31:16]}, 32'h3);
    $display("device clocked done");
    complete_run();
  end
endmodule
`default_nettype wire
